// ==== core/vpic_top.sv ====
// vectored priority interrupt controller with AXI4-Lite register slave
`timescale 1ns/1ps
module vpic_top
    import vpic_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_pin_a_n,
    input wire logic ext_pin_b_n,
    input wire logic [VPIC_NSRC-1:0] hw_flag_set,
    input wire logic [5:0] pca_flags,
    input wire logic last_cycle,
    input wire logic instr_is_return_from_interrupt,
    input wire logic sys_reset_req,
    output logic call_valid,
    output logic [15:0] call_vector,
    output logic [3:0] in_service
);
    typedef struct packed {
        logic [1:0] pa_sync;
        logic [1:0] pb_sync;
        logic pa_last;
        logic pb_last;
        logic [VPIC_NSRC-1:0] en;
        logic [VPIC_NSRC-1:0] prl;
        logic [VPIC_NSRC-1:0] prh;
        logic [VPIC_NSRC-1:0] flag;
        logic [VPIC_NSRC-1:0] flag_q;
        logic [7:0] ctrl;
        logic [3:0] act;
        logic blk;
        vpic_state_t st;
        logic [2:0] cnt;
        logic [15:0] vec;
        logic aw_ok;
        logic [7:0] aw_a;
        logic w_ok;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } vpic_st_t;

    vpic_st_t s_reg;
    vpic_st_t s_next;
    vpic_arb_if ab();
    logic [VPIC_NSRC-1:0] src_req;
    logic [2*VPIC_NSRC-1:0] src_lvl;
    logic [3:0] act_floor;

    vpic_arbiter u_arb (
        .ab(ab.arb)
    );

    // per-vector request, level, level-disable gating
    always_comb begin
        src_req = s_reg.flag_q & s_reg.en & {VPIC_NSRC{s_reg.ctrl[VPIC_CTRL_GIE]}};
        src_req[VPIC_SRC_PCA] = src_req[VPIC_SRC_PCA] | (|pca_flags & s_reg.en[VPIC_SRC_PCA]
            & s_reg.ctrl[VPIC_CTRL_GIE]);
        for (int i = 0; i < VPIC_NSRC; i++) begin
            src_lvl[2*i +: 2] = {s_reg.prh[i], s_reg.prl[i]};
            if (s_reg.ctrl[VPIC_CTRL_LDIS + int'({s_reg.prh[i], s_reg.prl[i]})]) begin
                src_req[i] = 1'b0;
            end
        end
        act_floor = 4'h0;
        for (int l = 0; l < 4; l++) begin
            if (s_reg.act[l]) begin
                act_floor = 4'(l);
            end
        end
    end

    assign ab.req = src_req;
    assign ab.lvl = src_lvl;
    assign ab.floor_lvl = act_floor;
    assign ab.any_active = |s_reg.act;

    // one next-state process for the whole block
    always_comb begin
        logic wr_go;
        logic rd_go;
        logic accept;
        logic [VPIC_NSRC-1:0] hw_clr;
        logic [VPIC_NSRC-1:0] sw_set;
        logic [VPIC_NSRC-1:0] sw_clr;
        logic [VPIC_NSRC-1:0] set_all;
        s_next = s_reg;
        wr_go = 1'b0;
        rd_go = 1'b0;
        accept = 1'b0;
        hw_clr = '0;
        sw_set = '0;
        sw_clr = '0;
        set_all = hw_flag_set;
        // pin synchronisers; only the second stage (bit 1) is used
        s_next.pa_sync = {s_reg.pa_sync[0], ext_pin_a_n};
        s_next.pb_sync = {s_reg.pb_sync[0], ext_pin_b_n};
        s_next.pa_last = s_reg.pa_sync[1];
        s_next.pb_last = s_reg.pb_sync[1];
        if (s_reg.ctrl[VPIC_CTRL_TRIGA]) begin
            set_all[VPIC_SRC_EXTA] = s_reg.pa_last & ~s_reg.pa_sync[1];
        end
        if (s_reg.ctrl[VPIC_CTRL_TRIGB]) begin
            set_all[VPIC_SRC_EXTB] = s_reg.pb_last & ~s_reg.pb_sync[1];
        end
        // AXI write channel capture
        if (s_axi_awvalid && !s_reg.aw_ok) begin
            s_next.aw_ok = 1'b1;
            s_next.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_ok) begin
            s_next.w_ok = 1'b1;
            s_next.w_d = s_axi_wdata;
            s_next.w_s = s_axi_wstrb;
        end
        wr_go = s_reg.aw_ok && s_reg.w_ok && !s_reg.bv;
        if (wr_go) begin
            s_next.aw_ok = 1'b0;
            s_next.w_ok = 1'b0;
            s_next.bv = 1'b1;
            s_next.br = VPIC_RESP_OKAY;
            s_next.blk = 1'b1;
            case (s_reg.aw_a)
                VPIC_OFF_EN: s_next.en = s_reg.w_d[VPIC_NSRC-1:0];
                VPIC_OFF_PRL: s_next.prl = s_reg.w_d[VPIC_NSRC-1:0];
                VPIC_OFF_PRH: s_next.prh = s_reg.w_d[VPIC_NSRC-1:0];
                VPIC_OFF_FLAG: begin
                    sw_set = s_reg.w_d[VPIC_NSRC-1:0];
                    sw_clr = s_reg.w_d[16 +: VPIC_NSRC];
                end
                VPIC_OFF_CTRL: s_next.ctrl = s_reg.w_d[7:0];
                default: s_next.br = VPIC_RESP_SLVERR;
            endcase
        end
        if (s_reg.bv && s_axi_bready) begin
            s_next.bv = 1'b0;
        end
        // AXI read channel
        rd_go = s_axi_arvalid && !s_reg.rv;
        if (rd_go) begin
            s_next.rv = 1'b1;
            s_next.rr = VPIC_RESP_OKAY;
            s_next.rd = 32'h0000_0000;
            case (s_axi_araddr)
                VPIC_OFF_EN: s_next.rd = 32'(s_reg.en);
                VPIC_OFF_PRL: s_next.rd = 32'(s_reg.prl);
                VPIC_OFF_PRH: s_next.rd = 32'(s_reg.prh);
                VPIC_OFF_FLAG: s_next.rd = 32'(s_reg.flag);
                VPIC_OFF_CTRL: s_next.rd = 32'(s_reg.ctrl);
                VPIC_OFF_STAT: s_next.rd = {12'h000, s_reg.vec, s_reg.act};
                default: s_next.rr = VPIC_RESP_SLVERR;
            endcase
        end
        if (s_reg.rv && s_axi_rready) begin
            s_next.rv = 1'b0;
        end
        // polling at the last cycle of each instruction; nothing is remembered
        accept = 1'b0;
        case (s_reg.st)
            VPIC_IDLE: begin
                if (sys_reset_req) begin
                    s_next.st = VPIC_RST;
                end else if (last_cycle) begin
                    s_next.blk = 1'b0;
                    if (instr_is_return_from_interrupt && |s_reg.act) begin
                        s_next.act[act_floor[1:0]] = 1'b0;
                    end
                    if (ab.hit && !s_reg.blk && !instr_is_return_from_interrupt && !wr_go) begin
                        accept = 1'b1;
                        s_next.st = VPIC_CALL;
                        s_next.cnt = 3'(VPIC_CALL_CYCLES - 1);
                        s_next.vec = vpic_vector(ab.win_src);
                        s_next.act[ab.win_lvl] = 1'b1;
                    end
                end
            end
            VPIC_CALL: begin
                if (sys_reset_req) begin
                    s_next.st = VPIC_RST;
                end else if (s_reg.cnt == 3'd0) begin
                    s_next.st = VPIC_IDLE;
                end else begin
                    s_next.cnt = s_reg.cnt - 3'd1;
                end
            end
            VPIC_RST: begin
                s_next.vec = VPIC_RESET_VEC;
                s_next.act = 4'h0;
                if (!sys_reset_req) begin
                    s_next.st = VPIC_IDLE;
                end
            end
            default: s_next.st = VPIC_IDLE;
        endcase
        if (accept) begin
            if (ab.win_src == 4'(VPIC_SRC_TMRA) || ab.win_src == 4'(VPIC_SRC_TMRB)) begin
                hw_clr[ab.win_src] = 1'b1;
            end
            if ((ab.win_src == 4'(VPIC_SRC_EXTA) && s_reg.ctrl[VPIC_CTRL_TRIGA])
                || (ab.win_src == 4'(VPIC_SRC_EXTB) && s_reg.ctrl[VPIC_CTRL_TRIGB])) begin
                hw_clr[ab.win_src] = 1'b1;
            end
        end
        // set wins over any clear
        s_next.flag = ((s_reg.flag & ~hw_clr & ~sw_clr) | set_all | sw_set);
        if (!s_reg.ctrl[VPIC_CTRL_TRIGA]) begin
            s_next.flag[VPIC_SRC_EXTA] = ~s_reg.pa_sync[1];
        end
        if (!s_reg.ctrl[VPIC_CTRL_TRIGB]) begin
            s_next.flag[VPIC_SRC_EXTB] = ~s_reg.pb_sync[1];
        end
        s_next.flag_q = s_reg.flag;
    end

    // single state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.pa_sync <= 2'b11;
            s_reg.pb_sync <= 2'b11;
            s_reg.pa_last <= 1'b1;
            s_reg.pb_last <= 1'b1;
            s_reg.st <= VPIC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready = !s_reg.aw_ok;
    assign s_axi_wready = !s_reg.w_ok;
    assign s_axi_bvalid = s_reg.bv;
    assign s_axi_bresp = s_reg.br;
    assign s_axi_arready = !s_reg.rv;
    assign s_axi_rvalid = s_reg.rv;
    assign s_axi_rdata = s_reg.rd;
    assign s_axi_rresp = s_reg.rr;
    assign call_valid = (s_reg.st == VPIC_CALL);
    assign call_vector = s_reg.vec;
    assign in_service = s_reg.act;

    property p_call_len;
        @(posedge aclk) disable iff (!aresetn)
        $rose(call_valid) ##0 (!sys_reset_req) [*3] |=> call_valid ##1 !call_valid;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call not four cycles");

    property p_gie;
        @(posedge aclk) disable iff (!aresetn)
        !s_reg.ctrl[VPIC_CTRL_GIE] |=> !$rose(call_valid);
    endproperty
    a_gie: assert property (p_gie) else $error("call with global enable off");

    property p_return_from_interrupt_block;
        @(posedge aclk) disable iff (!aresetn)
        (s_reg.st == VPIC_IDLE) && last_cycle && instr_is_return_from_interrupt |=> !call_valid;
    endproperty
    a_return_from_interrupt_block: assert property (p_return_from_interrupt_block) else $error("call after return");

    property p_vec_range;
        @(posedge aclk) disable iff (!aresetn)
        call_valid |-> call_vector[2:0] == 3'b011 && call_vector <= 16'h0063;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("bad vector");

    property p_mark;
        @(posedge aclk) disable iff (!aresetn)
        $rose(call_valid) |-> in_service[$past(ab.win_lvl)];
    endproperty
    a_mark: assert property (p_mark) else $error("no in-service mark");

    property p_tmr_clr;
        @(posedge aclk) disable iff (!aresetn)
        $rose(call_valid) && call_vector == 16'h000B && !$past(hw_flag_set[VPIC_SRC_TMRA], 1)
            |-> !s_reg.flag[VPIC_SRC_TMRA];
    endproperty
    a_tmr_clr: assert property (p_tmr_clr) else $error("timer flag kept");

    property p_rst;
        @(posedge aclk) disable iff (!aresetn)
        sys_reset_req ##1 sys_reset_req |=> call_vector == VPIC_RESET_VEC && !call_valid;
    endproperty
    a_rst: assert property (p_rst) else $error("reset not taking precedence");

    property p_preempt;
        @(posedge aclk) disable iff (!aresetn)
        $rose(call_valid) && $past(in_service[3]) |-> 1'b0;
    endproperty
    a_preempt: assert property (p_preempt) else $error("level 3 preempted");

    // enable and priority cannot change in the accepting cycle, since a write there blocks the poll
    property p_src_en;
        @(posedge aclk) disable iff (!aresetn)
        $rose(call_valid) |-> $past(s_reg.en[ab.win_src]);
    endproperty
    a_src_en: assert property (p_src_en) else $error("call from disabled source");

    property p_wr_block;
        @(posedge aclk) disable iff (!aresetn)
        (s_reg.st == VPIC_IDLE) && last_cycle && s_reg.blk |=> !$rose(call_valid);
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("call right after register write");

    property p_lvl_dis;
        @(posedge aclk) disable iff (!aresetn)
        $rose(call_valid) |-> !$past(s_reg.ctrl[VPIC_CTRL_LDIS + ab.win_lvl]);
    endproperty
    a_lvl_dis: assert property (p_lvl_dis) else $error("call at disabled level");

    // a fresh edge in the accepting cycle may set the flag again, so it is excluded
    property p_ext_clr;
        @(posedge aclk) disable iff (!aresetn)
        $rose(call_valid) && call_vector == 16'h0003 && $past(s_reg.ctrl[VPIC_CTRL_TRIGA])
            && !$past(s_reg.pa_last && !s_reg.pa_sync[1]) |-> !s_reg.flag[VPIC_SRC_EXTA];
    endproperty
    a_ext_clr: assert property (p_ext_clr) else $error("edge flag kept");

    property p_tmrb_clr;
        @(posedge aclk) disable iff (!aresetn)
        $rose(call_valid) && call_vector == 16'h001B && !$past(hw_flag_set[VPIC_SRC_TMRB], 1)
            |-> !s_reg.flag[VPIC_SRC_TMRB];
    endproperty
    a_tmrb_clr: assert property (p_tmrb_clr) else $error("timer b flag kept");

    // a return drops exactly the highest marker; no call can be accepted at that boundary
    property p_return_from_interrupt_clr;
        @(posedge aclk) disable iff (!aresetn)
        (s_reg.st == VPIC_IDLE) && last_cycle && instr_is_return_from_interrupt && !sys_reset_req && |s_reg.act
            |=> !in_service[$past(act_floor[1:0])] && $countones(in_service) + 1 == $countones($past(in_service));
    endproperty
    a_return_from_interrupt_clr: assert property (p_return_from_interrupt_clr) else $error("return marker wrong");
endmodule : vpic_top

// ==== core/vpic_pkg.sv ====
// package of constants and types for the vectored priority interrupt controller
package vpic_pkg;

    localparam int VPIC_NSRC = 13;
    localparam int VPIC_CALL_CYCLES = 4;
    localparam logic [15:0] VPIC_VEC_BASE = 16'h0003;
    localparam logic [15:0] VPIC_VEC_STEP = 16'h0008;
    localparam logic [15:0] VPIC_RESET_VEC = 16'h0000;
    localparam logic [7:0] VPIC_REG_RESET = 8'h00;
    // source index = vector slot
    localparam int VPIC_SRC_EXTA = 0;
    localparam int VPIC_SRC_TMRA = 1;
    localparam int VPIC_SRC_EXTB = 2;
    localparam int VPIC_SRC_TMRB = 3;
    localparam int VPIC_SRC_PCA = 6;
    // polling order, first wins within a level
    localparam logic [3:0] VPIC_POLL [VPIC_NSRC] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h4, 4'h5,
        4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
    // AXI register byte offsets
    localparam logic [7:0] VPIC_OFF_EN = 8'h00;
    localparam logic [7:0] VPIC_OFF_PRL = 8'h04;
    localparam logic [7:0] VPIC_OFF_PRH = 8'h08;
    localparam logic [7:0] VPIC_OFF_FLAG = 8'h0C;
    localparam logic [7:0] VPIC_OFF_CTRL = 8'h10;
    localparam logic [7:0] VPIC_OFF_STAT = 8'h14;
    localparam int VPIC_CTRL_GIE = 0;
    localparam int VPIC_CTRL_TRIGA = 1;
    localparam int VPIC_CTRL_TRIGB = 2;
    localparam int VPIC_CTRL_LDIS = 4;
    localparam logic [1:0] VPIC_RESP_OKAY = 2'b00;
    localparam logic [1:0] VPIC_RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        VPIC_IDLE = 3'b001,
        VPIC_CALL = 3'b010,
        VPIC_RST = 3'b100
    } vpic_state_t;

    // vector address of slot n
    function automatic logic [15:0] vpic_vector(input logic [3:0] n);
        vpic_vector = VPIC_VEC_BASE + 16'({n, 3'b000});
    endfunction : vpic_vector
endpackage : vpic_pkg

// ==== core/vpic_arb_if.sv ====
// interface between controller core and its priority arbiter
`timescale 1ns/1ps
interface vpic_arb_if;
    import vpic_pkg::*;
    logic [VPIC_NSRC-1:0] req;
    logic [2*VPIC_NSRC-1:0] lvl;
    logic [3:0] floor_lvl;
    logic any_active;
    logic hit;
    logic [3:0] win_src;
    logic [1:0] win_lvl;
    modport core (output req, output lvl, output floor_lvl, output any_active, input hit, input win_src,
        input win_lvl);
    modport arb (input req, input lvl, input floor_lvl, input any_active, output hit, output win_src,
        output win_lvl);
endinterface : vpic_arb_if

// ==== core/vpic_arbiter.sv ====
// combinational level and polling-order arbiter
`timescale 1ns/1ps
module vpic_arbiter
    import vpic_pkg::*;
(
    vpic_arb_if.arb ab
);
    // scan levels high to low, then polling order
    always_comb begin
        logic found;
        logic [3:0] s;
        found = 1'b0;
        s = 4'h0;
        ab.hit = 1'b0;
        ab.win_src = 4'h0;
        ab.win_lvl = 2'b00;
        for (int l = 3; l >= 0; l--) begin
            for (int k = 0; k < VPIC_NSRC; k++) begin
                s = VPIC_POLL[k];
                if (!found && ab.req[s] && ab.lvl[2*s +: 2] == 2'(l)
                    && (!ab.any_active || 4'(l) > ab.floor_lvl)) begin
                    found = 1'b1;
                    ab.hit = 1'b1;
                    ab.win_src = s;
                    ab.win_lvl = 2'(l);
                end
            end
        end
    end
endmodule : vpic_arbiter

// ==== dv/vpic_cpu_model.sv ====
// behavioural cpu sequencer that marks instruction boundaries for the controller
`timescale 1ns/1ps
module vpic_cpu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic call_busy,
    input wire logic return_from_interrupt_req,
    output logic last_cycle,
    output logic instr_is_return_from_interrupt
);
    logic [2:0] cnt_reg;
    logic [2:0] len_reg;
    // lengths walk 1..5 cycles so boundaries come both promptly and late
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 3'h0;
            len_reg <= 3'h1;
        end else if (call_busy) begin
            cnt_reg <= 3'h0;
        end else if (last_cycle) begin
            cnt_reg <= 3'h0;
            len_reg <= (len_reg == 3'h5) ? 3'h1 : len_reg + 3'h1;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end
    // no boundary inside the hardware call, which is itself the next instruction
    assign last_cycle = rst_n && !call_busy && (cnt_reg == len_reg - 3'h1);
    assign instr_is_return_from_interrupt = last_cycle && return_from_interrupt_req;
endmodule : vpic_cpu_model

// ==== dv/tb_vectored_priority_interrupt_ctrl.sv ====
// self-checking bench for the vectored priority interrupt controller
`timescale 1ns/1ps
module tb_vectored_priority_interrupt_ctrl;
    import vpic_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic ext_pin_a_n = 1'b1;
    logic ext_pin_b_n = 1'b1;
    logic [VPIC_NSRC-1:0] hw_flag_set = 13'h0000;
    logic [5:0] pca_flags = 6'h00;
    logic last_cycle;
    logic instr_is_return_from_interrupt;
    logic sys_reset_req = 1'b0;
    logic call_valid;
    logic [15:0] call_vector;
    logic [3:0] in_service;
    logic return_from_interrupt_req = 1'b0;
    int n_errors = 0;
    int compares = 0;
    int lat = 0;

    always #25 aclk = ~aclk;

    vpic_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_pin_a_n, .ext_pin_b_n, .hw_flag_set, .pca_flags, .last_cycle,
        .instr_is_return_from_interrupt, .sys_reset_req, .call_valid, .call_vector, .in_service);

    vpic_cpu_model cpu_u (.clk(aclk), .rst_n(aresetn), .call_busy(call_valid), .return_from_interrupt_req(return_from_interrupt_req),
        .last_cycle(last_cycle), .instr_is_return_from_interrupt(instr_is_return_from_interrupt));

    task automatic close_out();
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic pa;
        logic pd;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        pa = 1'b1;
        pd = 1'b1;
        while (pa || pd) begin
            @(posedge aclk);
            if (pa && s_axi_awready === 1'b1) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (pd && s_axi_wready === 1'b1) begin
                pd = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk("bresp", (a <= VPIC_OFF_CTRL) ? 32'(VPIC_RESP_OKAY) : 32'(VPIC_RESP_SLVERR), 32'(s_axi_bresp));
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask : axr

    // bounded wait for the call, then its vector, length and in-service markers
    task automatic exp_call(input logic [15:0] v, input logic [3:0] is);
        int i;
        int w;
        i = 0;
        w = 0;
        while (call_valid !== 1'b1 && i < 80) begin
            @(posedge aclk);
            i++;
        end
        chk("call_vector", {15'h0, 1'b1, v}, {15'h0, call_valid, call_vector});
        while (call_valid === 1'b1 && w < 10) begin
            @(posedge aclk);
            w++;
        end
        chk("call_cycles", 32'(VPIC_CALL_CYCLES), 32'(w));
        // cycles from the flag edge at entry to the first handler cycle
        lat = i + w - 1;
        chk("in_service", 32'(is), 32'(in_service));
    endtask : exp_call

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge aclk);
            chk("call_valid", 32'h0, 32'(call_valid));
        end
    endtask : quiet

    // the cpu flags its next boundary as an interrupt return
    task automatic do_return_from_interrupt();
        return_from_interrupt_req <= 1'b1;
        do @(posedge aclk); while (instr_is_return_from_interrupt !== 1'b1);
        return_from_interrupt_req <= 1'b0;
    endtask : do_return_from_interrupt

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axr(VPIC_OFF_EN, 32'h0, VPIC_RESP_OKAY);
        axr(VPIC_OFF_CTRL, 32'h0, VPIC_RESP_OKAY);
        axr(8'h40, 32'h0, VPIC_RESP_SLVERR);
        axw(8'h40, 32'h0);
        axw(VPIC_OFF_EN, 32'h00001FFF);
        axw(VPIC_OFF_CTRL, 32'h00000001);
        // software-raised timer a request, flag cleared by the call
        axw(VPIC_OFF_FLAG, 32'h00000002);
        exp_call(16'h000B, 4'h1);
        axr(VPIC_OFF_FLAG, 32'h0, VPIC_RESP_OKAY);
        axr(VPIC_OFF_STAT, 32'h000000B1, VPIC_RESP_OKAY);
        do_return_from_interrupt();
        @(posedge aclk);
        hw_flag_set <= 13'h0008;
        @(posedge aclk);
        hw_flag_set <= 13'h0000;
        exp_call(16'h001B, 4'h1);
        chk("latency", 32'h1, 32'(lat > 5 && lat < 14));
        do_return_from_interrupt();
        // global enable off, then a cancelled request is forgotten
        axw(VPIC_OFF_CTRL, 32'h0);
        axw(VPIC_OFF_FLAG, 32'h00000010);
        quiet(40);
        axr(VPIC_OFF_FLAG, 32'h00000010, VPIC_RESP_OKAY);
        axw(VPIC_OFF_FLAG, 32'h00100000);
        axw(VPIC_OFF_CTRL, 32'h00000001);
        quiet(40);
        // same-level tie: capture source polled ahead of slots 4 and 5
        axw(VPIC_OFF_CTRL, 32'h0);
        pca_flags <= 6'h05;
        axw(VPIC_OFF_FLAG, 32'h00000030);
        axw(VPIC_OFF_CTRL, 32'h00000001);
        exp_call(16'h0033, 4'h1);
        quiet(30);
        pca_flags <= 6'h04;
        do_return_from_interrupt();
        exp_call(16'h0033, 4'h1);
        pca_flags <= 6'h00;
        do_return_from_interrupt();
        exp_call(16'h0023, 4'h1);
        axw(VPIC_OFF_FLAG, 32'h00100000);
        do_return_from_interrupt();
        exp_call(16'h002B, 4'h1);
        axw(VPIC_OFF_FLAG, 32'h00200000);
        do_return_from_interrupt();
        quiet(30);
        // levels: slot 8 at 1, slot 9 at 2, slot 12 at 3
        axw(VPIC_OFF_PRL, 32'h00001100);
        axw(VPIC_OFF_PRH, 32'h00001200);
        axw(VPIC_OFF_CTRL, 32'h0);
        axw(VPIC_OFF_FLAG, 32'h00000300);
        axw(VPIC_OFF_CTRL, 32'h00000001);
        exp_call(16'h004B, 4'h4);
        axw(VPIC_OFF_FLAG, 32'h00001000);
        exp_call(16'h0063, 4'hC);
        axw(VPIC_OFF_FLAG, 32'h12000000);
        do_return_from_interrupt();
        @(posedge aclk);
        chk("in_service", 32'h4, 32'(in_service));
        do_return_from_interrupt();
        // the level 1 request waited behind level 2 and is served now
        exp_call(16'h0043, 4'h2);
        axw(VPIC_OFF_FLAG, 32'h01000000);
        do_return_from_interrupt();
        // level 1 disabled blocks slot 8 until re-enabled
        axw(VPIC_OFF_CTRL, 32'h00000021);
        axw(VPIC_OFF_FLAG, 32'h00000100);
        quiet(40);
        axw(VPIC_OFF_CTRL, 32'h00000001);
        exp_call(16'h0043, 4'h2);
        axw(VPIC_OFF_FLAG, 32'h01000000);
        do_return_from_interrupt();
        // pin a edge mode then level mode
        axw(VPIC_OFF_CTRL, 32'h00000003);
        ext_pin_a_n <= 1'b0;
        exp_call(16'h0003, 4'h1);
        axr(VPIC_OFF_FLAG, 32'h0, VPIC_RESP_OKAY);
        do_return_from_interrupt();
        axw(VPIC_OFF_CTRL, 32'h00000001);
        exp_call(16'h0003, 4'h1);
        axr(VPIC_OFF_FLAG, 32'h00000001, VPIC_RESP_OKAY);
        ext_pin_a_n <= 1'b1;
        repeat (4) @(posedge aclk);
        do_return_from_interrupt();
        quiet(30);
        // system reset request while a routine is in service
        axw(VPIC_OFF_FLAG, 32'h00000002);
        exp_call(16'h000B, 4'h1);
        sys_reset_req <= 1'b1;
        quiet(5);
        chk("call_vector", 32'h0, 32'(call_vector));
        chk("in_service", 32'h0, 32'(in_service));
        sys_reset_req <= 1'b0;
        close_out();
    end
endmodule : tb_vectored_priority_interrupt_ctrl
